/* shared/simd_pkg.sv */
// shared constants, types and rounding helper of the packed integer datapath
package simd_pkg;

    // operand widths
    localparam int NARROW_W = 64;
    localparam int WIDE_W = 128;
    localparam int GPR_W = 32;

    // vector control/status register layout
    localparam logic [31:0] CSR_RESET = 32'h0000_1F80;
    localparam logic [31:0] CSR_WRITABLE = 32'h0000_FFFF;
    localparam int CSR_RC_LSB = 13;
    localparam int CSR_FLAG_INVALID = 0;
    localparam int CSR_FLAG_PRECISION = 5;

    // single-precision fields and conversion limits
    localparam logic [7:0] F32_EXP_MAX = 8'hFF;
    localparam logic [7:0] F2I_EXP_TOP = 8'h9E;
    localparam logic [7:0] F2I_EXP_TINY = 8'h76;
    localparam logic [7:0] I2F_EXP_TOP = 8'h9E;
    localparam logic [31:0] INT_INDEFINITE = 32'h8000_0000;
    localparam logic [32:0] INT_POS_LIMIT = 33'h0_8000_0000;

    // rounding control field, in encoding order
    typedef enum logic [1:0] {
        RND_NEAREST,
        RND_DOWN,
        RND_UP,
        RND_ZERO
    } round_mode_t;

    // operations issued to the datapath
    typedef enum logic [4:0] {
        NOP,
        AVG_UNSIGNED_BYTES,
        AVG_UNSIGNED_WORDS,
        WORD_EXTRACT_OP,
        WORD_INSERT_OP,
        MAX_UNSIGNED_BYTES,
        MIN_UNSIGNED_BYTES,
        MAX_SIGNED_WORDS,
        MIN_SIGNED_WORDS,
        BYTE_SIGN_MASK_OP,
        UNSIGNED_HIGH_MULTIPLY,
        SUM_ABS_DIFF_OP,
        WORD_SHUFFLE_OP,
        INT_TO_SCALAR_FLOAT,
        PACKED_FLOAT_TO_INT,
        PACKED_FLOAT_TO_INT_TRUNC,
        SCALAR_FLOAT_TO_INT,
        SCALAR_FLOAT_TO_INT_TRUNC,
        VECTOR_CSR_LOAD,
        VECTOR_CSR_STORE
    } simd_op_t;

    // request from issue logic
    typedef struct packed {
        logic valid;
        simd_op_t op;
        logic wide;
        logic from_mem;
        logic [7:0] imm;
        logic [WIDE_W-1:0] src_a;
        logic [WIDE_W-1:0] src_b;
        logic [GPR_W-1:0] gpr_in;
        logic [GPR_W-1:0] mem_in;
    } simd_req_t;

    // result towards register files and memory
    typedef struct packed {
        logic valid;
        logic vec_we;
        logic [WIDE_W-1:0] vec;
        logic gpr_we;
        logic [GPR_W-1:0] gpr;
        logic mem_we;
        logic [GPR_W-1:0] mem;
    } simd_resp_t;

    // magnitude increment for a given rounding mode
    function automatic logic round_inc(input round_mode_t mode,
                                       input logic sign, input logic lsb,
                                       input logic guard, input logic sticky);
        case (mode)
            RND_NEAREST: round_inc = guard & (sticky | lsb);
            RND_DOWN: round_inc = sign & (guard | sticky);
            RND_UP: round_inc = ~sign & (guard | sticky);
            default: round_inc = 1'b0;
        endcase
    endfunction

endpackage

/* hdl/cvt_f2i.sv */
// single-precision to signed doubleword converter, one lane
module cvt_f2i (
    // operand and mode
    input wire logic [31:0] fp_in,
    input wire simd_pkg::round_mode_t mode,
    // result and flags
    output logic [31:0] int_out,
    output logic inexact,
    output logic invalid
);
    import simd_pkg::*;

    logic sign;
    logic [7:0] expo;
    logic [23:0] mant;
    logic huge;
    logic tiny;
    logic [5:0] sh;
    logic [63:0] fixed;
    logic [31:0] ipart;
    logic guard;
    logic sticky;
    logic inc;
    logic [32:0] mag;
    logic ovf;

    // field split, hidden bit only for normal numbers
    assign sign = fp_in[31];
    assign expo = fp_in[30:23];
    assign mant = {|expo, fp_in[22:0]};
    assign huge = expo > F2I_EXP_TOP;
    assign tiny = expo < F2I_EXP_TINY;

    // 32.32 fixed point; tiny values only leave a sticky bit
    assign sh = (tiny | huge) ? 6'h00 : 6'(expo - F2I_EXP_TINY);
    assign fixed = {40'h00_0000_0000, mant} << sh;
    assign ipart = tiny ? 32'h0000_0000 : fixed[63:32];
    assign guard = tiny ? 1'b0 : fixed[31];
    assign sticky = tiny ? (|fp_in[30:0]) : (|fixed[30:0]);

    assign inc = round_inc(mode, sign, ipart[0], guard, sticky);
    assign mag = {1'b0, ipart} + 33'(inc);

    // out of range, nan or infinity gives the indefinite integer
    assign ovf = huge | (expo == F32_EXP_MAX)
               | (sign ? (mag > INT_POS_LIMIT) : (mag >= INT_POS_LIMIT));
    assign int_out = ovf ? INT_INDEFINITE
                   : (sign ? 32'(33'h0_0000_0000 - mag) : mag[31:0]);
    assign inexact = ~ovf & (guard | sticky);
    assign invalid = ovf;

endmodule

/* hdl/cvt_i2f.sv */
// signed doubleword to single-precision converter
module cvt_i2f (
    // operand and mode
    input wire logic [31:0] int_in,
    input wire simd_pkg::round_mode_t mode,
    // result and flag
    output logic [31:0] fp_out,
    output logic inexact
);
    import simd_pkg::*;

    logic sign;
    logic [31:0] absval;
    logic [4:0] lz;
    logic [31:0] norm;
    logic inc;
    logic [23:0] rounded;
    logic [7:0] expo;

    assign sign = int_in[31];
    assign absval = sign ? 32'(33'h0_0000_0000 - {1'b0, int_in}) : int_in;

    // leading zero count, highest set bit wins
    always_comb begin
        lz = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (absval[i]) begin
                lz = 5'(31 - i);
            end
        end
    end

    // normalise, round, adjust exponent on carry
    assign norm = absval << lz;
    assign inc = round_inc(mode, sign, norm[8], norm[7], |norm[6:0]);
    assign rounded = {1'b0, norm[30:8]} + 24'(inc);
    assign expo = 8'(I2F_EXP_TOP - {3'h0, lz}) + {7'h00, rounded[23]};
    assign fp_out = (absval == 32'h0000_0000) ? 32'h0000_0000
                  : {sign, expo, rounded[22:0]};
    assign inexact = (|absval) & (norm[7] | (|norm[6:0]));

endmodule

/* hdl/simd_int_datapath.sv */
// packed integer, conversion and control/status datapath, one cycle latency
// How it works
// - packed integer ops read 64-bit register or memory operands
// - with the wide option the same ops accept 128-bit operands
// - averages add pairs, add one, shift right one bit
// - word extract copies one selected word to the gpr result
// - word insert places a gpr or memory word into a chosen slot
// - unsigned byte max and min pick greater or lesser per pair
// - signed word max and min pick greater or lesser per pair
// - byte mask gathers each byte msb into an 8-bit gpr value
// - on 128-bit operands the byte mask is 16 bits
// - unsigned high multiply returns the high word of each product
// - sum of absolute byte differences lands in the low word of each 64-bit half
// - word shuffle reorders source words under an 8-bit immediate
// - integer to scalar float converts one signed doubleword
// - inexact rounding conversions follow the csr rounding mode
// - packed float to int converts two singles to two doublewords
// - scalar float to int converts one single to a doubleword
// - truncating conversions round toward zero, otherwise identical
// - csr load fills the register from memory, store writes it out
module simd_int_datapath #(
    parameter bit HAS_WIDE = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // issued operation
    input wire simd_pkg::simd_req_t req,
    // registered result
    output simd_pkg::simd_resp_t resp,
    // current control/status value
    output logic [31:0] csr_value
);
    import simd_pkg::*;

    localparam int BYTES = WIDE_W / 8;
    localparam int WORDS = WIDE_W / 16;

    logic [31:0] csr;
    logic [31:0] next_csr;
    simd_resp_t next_resp;

    logic wide_en;
    logic [WIDE_W-1:0] vec_mask;
    logic [WIDE_W-1:0] avg_b;
    logic [WIDE_W-1:0] avg_w;
    logic [WIDE_W-1:0] max_ub;
    logic [WIDE_W-1:0] min_ub;
    logic [WIDE_W-1:0] max_sw;
    logic [WIDE_W-1:0] min_sw;
    logic [WIDE_W-1:0] mulhi;
    logic [WIDE_W-1:0] absd;
    logic [WIDE_W-1:0] shuf;
    logic [WIDE_W-1:0] inserted;
    logic [WIDE_W-1:0] sad_vec;
    logic [BYTES-1:0] msb_bits;
    logic [10:0] sad_lo;
    logic [10:0] sad_hi;
    logic [2:0] word_sel;
    logic [15:0] ext_word;
    logic [15:0] ins_word;
    logic [15:0] byte_mask;

    round_mode_t csr_mode;
    round_mode_t f2i_mode;
    logic f2i_trunc;
    logic [63:0] f2i_res;
    logic [1:0] f2i_inexact;
    logic [1:0] f2i_invalid;
    logic [31:0] i2f_res;
    logic i2f_inexact;

    logic [WIDE_W-1:0] next_vec;
    logic vec_we;
    logic [31:0] next_gpr;
    logic gpr_we;
    logic [31:0] next_mem;
    logic mem_we;
    logic flag_inexact;
    logic flag_invalid;
    logic csr_load;
    logic [31:0] flag_bits;

    // operand width, wide only when the option is built in
    assign wide_en = req.wide & HAS_WIDE;
    assign vec_mask = wide_en ? {WIDE_W{1'b1}}
                    : {{(WIDE_W-NARROW_W){1'b0}}, {NARROW_W{1'b1}}};

    // byte lanes: average, max, min, absolute difference, sign bit
    for (genvar b = 0; b < BYTES; b++) begin : g_byte
        logic [7:0] ea;
        logic [7:0] eb;
        logic [8:0] sum9;
        logic a_gt;
        assign ea = req.src_a[8*b +: 8];
        assign eb = req.src_b[8*b +: 8];
        // nine-bit sum plus one, then shift
        assign sum9 = {1'b0, ea} + {1'b0, eb} + 9'h001;
        assign avg_b[8*b +: 8] = sum9[8:1];
        assign a_gt = ea > eb;
        assign max_ub[8*b +: 8] = a_gt ? ea : eb;
        assign min_ub[8*b +: 8] = a_gt ? eb : ea;
        assign absd[8*b +: 8] = a_gt ? 8'(ea - eb) : 8'(eb - ea);
        assign msb_bits[b] = ea[7];
    end

    // word lanes: average, signed max and min, high product, shuffle
    for (genvar w = 0; w < WORDS; w++) begin : g_word
        logic [15:0] wa;
        logic [15:0] wb;
        logic [16:0] sum17;
        logic [31:0] prod;
        logic s_gt;
        logic [2:0] sidx;
        assign wa = req.src_a[16*w +: 16];
        assign wb = req.src_b[16*w +: 16];
        // seventeen-bit sum plus one, then shift
        assign sum17 = {1'b0, wa} + {1'b0, wb} + 17'h0_0001;
        assign avg_w[16*w +: 16] = sum17[16:1];
        assign s_gt = $signed(wa) > $signed(wb);
        assign max_sw[16*w +: 16] = s_gt ? wa : wb;
        assign min_sw[16*w +: 16] = s_gt ? wb : wa;
        assign prod = wa * wb;
        assign mulhi[16*w +: 16] = prod[31:16];
        // two immediate bits pick a word of the same half
        assign sidx = {1'(w / 4), req.imm[2*(w % 4) +: 2]};
        assign shuf[16*w +: 16] = req.src_b[16*sidx +: 16];
    end

    // byte difference totals per 64-bit half
    always_comb begin
        sad_lo = 11'h000;
        sad_hi = 11'h000;
        for (int i = 0; i < 8; i++) begin
            sad_lo = sad_lo + 11'(absd[8*i +: 8]);
            sad_hi = sad_hi + 11'(absd[NARROW_W + 8*i +: 8]);
        end
    end
    assign sad_vec = {48'h0000_0000_0000, 5'h00, sad_hi,
                      48'h0000_0000_0000, 5'h00, sad_lo};

    // word position: four slots narrow, eight slots wide
    assign word_sel = wide_en ? req.imm[2:0] : {1'b0, req.imm[1:0]};
    // selected word of the source register
    assign ext_word = req.src_b[16*word_sel +: 16];
    // word from memory or gpr into the chosen slot
    assign ins_word = req.from_mem ? req.mem_in[15:0] : req.gpr_in[15:0];

    // destination copy with one word replaced
    for (genvar w = 0; w < WORDS; w++) begin : g_ins
        assign inserted[16*w +: 16] = (word_sel == 3'(w)) ? ins_word
                                    : req.src_a[16*w +: 16];
    end

    // eight mask bits narrow, sixteen wide
    assign byte_mask = wide_en ? msb_bits
                     : {8'h00, msb_bits[NARROW_W/8-1:0]};

    // truncating forms force round toward zero
    assign csr_mode = round_mode_t'(csr[CSR_RC_LSB +: 2]);
    assign f2i_trunc = (req.op == PACKED_FLOAT_TO_INT_TRUNC)
                     | (req.op == SCALAR_FLOAT_TO_INT_TRUNC);
    assign f2i_mode = f2i_trunc ? RND_ZERO : csr_mode;

    // two converter lanes, lane 0 serves the scalar form
    for (genvar c = 0; c < 2; c++) begin : g_f2i
        cvt_f2i u_f2i (
            .fp_in(req.src_b[32*c +: 32]),
            .mode(f2i_mode),
            .int_out(f2i_res[32*c +: 32]),
            .inexact(f2i_inexact[c]),
            .invalid(f2i_invalid[c])
        );
    end

    // integer source taken from the gpr operand
    cvt_i2f u_i2f (
        .int_in(req.gpr_in),
        .mode(csr_mode),
        .fp_out(i2f_res),
        .inexact(i2f_inexact)
    );

    // result selection by operation
    always_comb begin
        next_vec = req.src_a;
        vec_we = 1'b0;
        next_gpr = 32'h0000_0000;
        gpr_we = 1'b0;
        next_mem = 32'h0000_0000;
        mem_we = 1'b0;
        flag_inexact = 1'b0;
        flag_invalid = 1'b0;
        csr_load = 1'b0;
        case (req.op)
            AVG_UNSIGNED_BYTES: begin
                next_vec = avg_b;
                vec_we = 1'b1;
            end

            AVG_UNSIGNED_WORDS: begin
                next_vec = avg_w;
                vec_we = 1'b1;
            end

            WORD_EXTRACT_OP: begin
                next_gpr = {16'h0000, ext_word};
                gpr_we = 1'b1;
            end

            WORD_INSERT_OP: begin
                next_vec = inserted;
                vec_we = 1'b1;
            end

            MAX_UNSIGNED_BYTES: begin
                next_vec = max_ub;
                vec_we = 1'b1;
            end

            MIN_UNSIGNED_BYTES: begin
                next_vec = min_ub;
                vec_we = 1'b1;
            end

            MAX_SIGNED_WORDS: begin
                next_vec = max_sw;
                vec_we = 1'b1;
            end

            MIN_SIGNED_WORDS: begin
                next_vec = min_sw;
                vec_we = 1'b1;
            end

            BYTE_SIGN_MASK_OP: begin
                next_gpr = {16'h0000, byte_mask};
                gpr_we = 1'b1;
            end

            UNSIGNED_HIGH_MULTIPLY: begin
                next_vec = mulhi;
                vec_we = 1'b1;
            end

            SUM_ABS_DIFF_OP: begin
                next_vec = sad_vec;
                vec_we = 1'b1;
            end

            WORD_SHUFFLE_OP: begin
                next_vec = shuf;
                vec_we = 1'b1;
            end

            INT_TO_SCALAR_FLOAT: begin
                next_vec = {req.src_a[WIDE_W-1:32], i2f_res};
                vec_we = 1'b1;
                flag_inexact = i2f_inexact;
            end

            PACKED_FLOAT_TO_INT, PACKED_FLOAT_TO_INT_TRUNC: begin
                next_vec = {{(WIDE_W-NARROW_W){1'b0}}, f2i_res};
                vec_we = 1'b1;
                flag_inexact = |f2i_inexact;
                flag_invalid = |f2i_invalid;
            end

            SCALAR_FLOAT_TO_INT, SCALAR_FLOAT_TO_INT_TRUNC: begin
                next_gpr = f2i_res[31:0];
                gpr_we = 1'b1;
                flag_inexact = f2i_inexact[0];
                flag_invalid = f2i_invalid[0];
            end

            VECTOR_CSR_LOAD: begin
                csr_load = 1'b1;
            end

            VECTOR_CSR_STORE: begin
                next_mem = csr;
                mem_we = 1'b1;
            end

            // nop and unused codes write nothing
            default: begin
            end
        endcase
    end

    // sticky exception flags raised by conversions
    assign flag_bits = (32'(flag_invalid) << CSR_FLAG_INVALID)
                     | (32'(flag_inexact) << CSR_FLAG_PRECISION);

    // load replaces the register, otherwise flags accumulate
    assign next_csr = (req.valid & csr_load) ? (req.mem_in & CSR_WRITABLE)
                    : (req.valid ? (csr | flag_bits) : csr);

    // response word, narrow results clear the upper half
    assign next_resp.valid = req.valid;
    assign next_resp.vec_we = req.valid & vec_we;
    assign next_resp.vec = next_vec & vec_mask;
    assign next_resp.gpr_we = req.valid & gpr_we;
    assign next_resp.gpr = next_gpr;
    assign next_resp.mem_we = req.valid & mem_we;
    assign next_resp.mem = next_mem;

    // result and control/status registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resp <= '0;
            csr <= CSR_RESET;
        end else begin
            resp <= next_resp;
            csr <= next_csr;
        end
    end

    assign csr_value = csr;

endmodule

/* tb/simd_dp_checker.sv */
// port assertions for the packed integer datapath
module simd_dp_checker #(
    parameter bit HAS_WIDE = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request, result, control/status
    input wire simd_pkg::simd_req_t req,
    input wire simd_pkg::simd_resp_t resp,
    input wire logic [31:0] csr_value
);
    timeunit 1ns;
    timeprecision 100ps;
    import simd_pkg::*;

    logic [8:0] avg_sum;
    logic [31:0] prod;
    logic [63:0] ext;
    logic [15:0] msk;

    // lane 0 reference terms, selected word, byte sign gather
    assign avg_sum = {1'b0, req.src_a[7:0]} + {1'b0, req.src_b[7:0]} + 9'h001;
    assign prod = req.src_a[15:0] * req.src_b[15:0];
    assign ext = req.src_b[63:0] >> {req.imm[1:0], 4'h0};
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            msk[i] = req.src_a[8*i+7];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_valid;
        req.valid |=> resp.valid;
    endproperty
    a_valid: assert property (p_valid)
        else $error("result valid missing");
    property p_narrow;
        req.valid && !(req.wide && HAS_WIDE) && req.op inside {
            AVG_UNSIGNED_BYTES,
            MAX_SIGNED_WORDS, UNSIGNED_HIGH_MULTIPLY}
        |=> resp.vec_we && resp.vec[127:64] == 64'h0;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("narrow op touched upper half");
    property p_mask;
        req.valid && !req.wide && req.op == BYTE_SIGN_MASK_OP
        |=> resp.gpr_we && resp.gpr == {24'h0, $past(msk[7:0])};
    endproperty
    a_mask: assert property (p_mask)
        else $error("byte mask wrong");
    property p_avg;
        req.valid && req.op == AVG_UNSIGNED_BYTES
        |=> resp.vec[7:0] == $past(avg_sum[8:1]);
    endproperty
    a_avg: assert property (p_avg)
        else $error("byte average wrong");
    property p_mulhi;
        req.valid && req.op == UNSIGNED_HIGH_MULTIPLY
        |=> resp.vec[15:0] == $past(prod[31:16]);
    endproperty
    a_mulhi: assert property (p_mulhi)
        else $error("high product wrong");
    property p_maxub;
        req.valid && req.op == MAX_UNSIGNED_BYTES
        |=> resp.vec[7:0] >= $past(req.src_a[7:0])
            && resp.vec[7:0] >= $past(req.src_b[7:0]);
    endproperty
    a_maxub: assert property (p_maxub)
        else $error("unsigned byte max wrong");
    property p_minsw;
        req.valid && req.op == MIN_SIGNED_WORDS
        |=> $signed(resp.vec[15:0]) <= $signed($past(req.src_a[15:0]))
            && $signed(resp.vec[15:0]) <= $signed($past(req.src_b[15:0]));
    endproperty
    a_minsw: assert property (p_minsw)
        else $error("signed word min wrong");
    property p_extract;
        req.valid && !req.wide && req.op == WORD_EXTRACT_OP
        |=> resp.gpr_we && resp.gpr == {16'h0, $past(ext[15:0])};
    endproperty
    a_extract: assert property (p_extract)
        else $error("extracted word wrong");
    property p_csr_load;
        req.valid && req.op == VECTOR_CSR_LOAD
        |=> csr_value == ($past(req.mem_in) & CSR_WRITABLE);
    endproperty
    a_csr_load: assert property (p_csr_load)
        else $error("csr load wrong");
    property p_csr_store;
        req.valid && req.op == VECTOR_CSR_STORE
        |=> resp.mem_we && resp.mem == $past(csr_value);
    endproperty
    a_csr_store: assert property (p_csr_store)
        else $error("csr store wrong");
endmodule

bind simd_int_datapath simd_dp_checker #(.HAS_WIDE(HAS_WIDE)) i_chk (
    .clk(clk), .rstn(rstn), .req(req), .resp(resp), .csr_value(csr_value));

/* tb/issue_model.sv */
// issue logic model driving one request per call
module issue_model (
    // clock
    input wire logic clk,
    // request towards the datapath
    output simd_pkg::simd_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;
    import simd_pkg::*;

    // nothing issued until the first call
    initial req = '0;

    // present one operation at the next edge
    task automatic issue(input simd_req_t r);
        @(posedge clk);
        req <= r;
    endtask

    // drop valid, operands go to their inverse so stale data never matches
    task automatic idle();
        simd_req_t t;
        @(posedge clk);
        t = ~req;
        t.valid = 1'b0;
        req <= t;
    endtask
endmodule

/* tb/tb_simd_int_datapath.sv */
// self-checking bench of the packed integer datapath
module tb_simd_int_datapath;
    timeunit 1ns;
    timeprecision 100ps;
    import simd_pkg::*;

    localparam logic [63:0] W4 = 64'h4444_3333_2222_1111;
    localparam logic [63:0] AA = 64'h00FF_0180_FF00_7FFE;
    localparam logic [63:0] AB = 64'h01FF_0080_0000_80FE;
    localparam logic [63:0] AE = 64'h01FF_0180_8000_80FE;
    logic clk;
    logic rstn;
    simd_req_t req;
    simd_resp_t resp;
    logic [31:0] csr_value;
    int miscompares = 0;
    int samples_checked = 0;

    // core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    issue_model i_issue_model (.clk(clk), .req(req));
    simd_int_datapath #(.HAS_WIDE(1'b1)) i_simd_int_datapath (
        .clk(clk), .rstn(rstn), .req(req), .resp(resp),
        .csr_value(csr_value));

    // compare and count
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("BAD %0t got %h want %h", $time, seen, exp);
            miscompares++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic simd_req_t mk(simd_op_t op, logic [127:0] a,
        logic [127:0] b, logic [7:0] imm = 8'h00, logic w = 1'h0,
        logic fm = 1'h0, logic [31:0] g = 32'h0, logic [31:0] m = 32'h0);
        mk = '{1'b1, op, w, fm, imm, a, b, g, m};
    endfunction

    // one op, then idle, result settled on return
    task automatic go(input simd_req_t r);
        i_issue_model.issue(r);
        i_issue_model.idle();
        #1;
    endtask

    // byte averages narrow and wide, word averages narrow, carry at the top of a lane
    task automatic t_avg();
        go(mk(AVG_UNSIGNED_BYTES, AA, AB));
        chk(resp.vec, {64'h0, AE});
        go(mk(AVG_UNSIGNED_BYTES, {AA, AA}, {AB, AB}, 8'h00, 1'h1));
        chk(resp.vec, {AE, AE});
        go(mk(AVG_UNSIGNED_WORDS, 64'hFFFF_0001_0000_8000,
            64'hFFFF_0000_0001_7FFF));
        chk(resp.vec, {64'h0, 64'hFFFF_0001_0001_8000});
        $display("test avg finished");
    endtask

    // all four compare ops on mixed sign lanes
    task automatic t_maxmin();
        simd_op_t ops[4] = '{MAX_UNSIGNED_BYTES, MIN_UNSIGNED_BYTES,
            MAX_SIGNED_WORDS, MIN_SIGNED_WORDS};
        logic [63:0] e[4] = '{64'h8002_FFFF_80FF_80FF,
            64'h7F01_0000_7F00_7F00, 64'h7F02_00FF_7FFF_7FFF,
            64'h8001_FF00_8000_8000};
        for (int i = 0; i < 4; i++) begin
            go(mk(ops[i], 64'h8001_FF00_7FFF_8000, 64'h7F02_00FF_8000_7FFF));
            chk(resp.vec, {64'h0, e[i]});
        end
        $display("test maxmin finished");
    endtask

    // extract, insert from gpr and memory, shuffle
    task automatic t_word();
        go(mk(WORD_EXTRACT_OP, 128'h0, W4, 8'h03));
        chk(resp.gpr, 32'h0000_4444);
        go(mk(WORD_INSERT_OP, W4, 128'h0, 8'h01, 1'h0, 1'h0, 32'hDEAD_BEEF));
        chk(resp.vec, 128'h4444_3333_BEEF_1111);
        go(mk(WORD_INSERT_OP, W4, 128'h0, 8'h03, 1'h0, 1'h1, 32'h0,
            32'h0000_CAFE));
        chk(resp.vec, 128'hCAFE_3333_2222_1111);
        go(mk(WORD_SHUFFLE_OP, 128'h0, W4, 8'h1B));
        chk(resp.vec, 128'h1111_2222_3333_4444);
        $display("test word finished");
    endtask

    // byte mask, high multiply, absolute difference sums
    task automatic t_arith();
        go(mk(BYTE_SIGN_MASK_OP, 64'h807F_FF00_8101_C040, 128'h0));
        chk(resp.gpr, 32'h0000_00AA);
        go(mk(BYTE_SIGN_MASK_OP, {64'h8000_0000_0000_0080,
            64'h807F_FF00_8101_C040}, 128'h0, 8'h00, 1'h1));
        chk(resp.gpr, 32'h0000_81AA);
        go(mk(UNSIGNED_HIGH_MULTIPLY, 64'hFFFF_8000_0002_1234,
            64'hFFFF_8000_8000_0010));
        chk(resp.vec, 128'hFFFE_4000_0001_0001);
        go(mk(SUM_ABS_DIFF_OP, 64'hFF00_FF00_FF00_FF00,
            64'h00FF_00FF_00FF_00FF));
        chk(resp.vec, 128'h07F8);
        go(mk(SUM_ABS_DIFF_OP, {2{64'hFF00_FF00_FF00_FF00}},
            {2{64'h00FF_00FF_00FF_00FF}}, 8'h00, 1'h1));
        chk(resp.vec, {48'h0, 16'h07F8, 48'h0, 16'h07F8});
        $display("test arith finished");
    endtask

    // every rounding mode, csr load right before a conversion
    task automatic t_cvt();
        logic [31:0] pos[4] = '{32'h2, 32'h2, 32'h3, 32'h2};
        logic [31:0] neg[4] = '{32'hFFFF_FFFE, 32'hFFFF_FFFD,
            32'hFFFF_FFFE, 32'hFFFF_FFFE};
        logic [31:0] i2f[4] = '{32'h4B80_0000, 32'h4B80_0000,
            32'h4B80_0001, 32'h4B80_0000};
        logic [63:0] pk[4] = '{64'hFFFF_FFFE_0000_0002,
            64'hFFFF_FFFE_0000_0001, 64'hFFFF_FFFF_0000_0002,
            64'hFFFF_FFFF_0000_0001};
        logic [31:0] ld;
        for (int md = 0; md < 4; md++) begin
            ld = {16'hFFFF, 1'h0, md[1:0], 13'h1F80};
            i_issue_model.issue(mk(VECTOR_CSR_LOAD, 128'h0, 128'h0, 8'h00,
                1'h0, 1'h0, 32'h0, ld));
            i_issue_model.issue(mk(SCALAR_FLOAT_TO_INT, 128'h0,
                32'h4020_0000));
            #1;
            chk(csr_value, {16'h0, ld[15:0]});
            i_issue_model.idle();
            #1;
            chk(resp.gpr, pos[md]);
            go(mk(SCALAR_FLOAT_TO_INT, 128'h0, 32'hC020_0000));
            chk(resp.gpr, neg[md]);
            go(mk(SCALAR_FLOAT_TO_INT_TRUNC, 128'h0, 32'hC020_0000));
            chk(resp.gpr, 32'hFFFF_FFFE);
            go(mk(INT_TO_SCALAR_FLOAT, 128'h0, 128'h0, 8'h00, 1'h0, 1'h0,
                32'h0100_0001));
            chk(resp.vec[31:0], i2f[md]);
            go(mk(PACKED_FLOAT_TO_INT, 128'h0, 64'hBFC0_0000_3FC0_0000));
            chk(resp.vec, {64'h0, pk[md]});
            go(mk(PACKED_FLOAT_TO_INT_TRUNC, 128'h0, 64'hBFC0_0000_3FC0_0000));
            chk(resp.vec, 128'hFFFF_FFFF_0000_0001);
            go(mk(VECTOR_CSR_STORE, 128'h0, 128'h0));
            chk(resp.mem, {16'h0, ld[15:0]} | 32'h20);
        end
        // out of range gives the indefinite integer and raises invalid
        go(mk(SCALAR_FLOAT_TO_INT, 128'h0, 32'h4F00_0000));
        chk(resp.gpr, INT_INDEFINITE);
        go(mk(VECTOR_CSR_STORE, 128'h0, 128'h0));
        chk(resp.mem, {16'h0, ld[15:0]} | 32'h21);
        $display("test cvt finished");
    endtask

    // run cut short if a wait hangs
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end

    // reset, then the scenarios
    initial begin
        rstn = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk(csr_value, CSR_RESET);
        chk({resp.valid, resp.vec_we, resp.gpr_we, resp.mem_we}, 4'h0);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        go(mk(NOP, W4, W4));
        chk({resp.valid, resp.vec_we, resp.gpr_we, resp.mem_we}, 4'h8);
        $display("test reset finished");
        t_avg();
        t_maxmin();
        t_word();
        t_arith();
        t_cvt();
        summarize();
    end
endmodule
